// ---- event_capture_pkg.sv ----
package event_capture_pkg;

  // register addresses as seen on the serial register port
  localparam logic [6:0] SYS_EN_ADDR = 7'h04;
  localparam logic [6:0] SUP_EN_ADDR = 7'h1C;
  localparam logic [6:0] TRX_EN_ADDR = 7'h23;
  localparam logic [6:0] WAKE_EN_ADDR = 7'h4C;
  localparam logic [6:0] SYS_ST_ADDR = 7'h61;
  localparam logic [6:0] SUP_ST_ADDR = 7'h62;
  localparam logic [6:0] TRX_ST_ADDR = 7'h63;
  localparam logic [6:0] WAKE_ST_ADDR = 7'h64;

  // bit positions; each enable bit sits at the same position as its status bit
  localparam int OVERTEMP_BIT = 2;
  localparam int SERIAL_FAULT_BIT = 1;
  localparam int AUX_OVER_BIT = 2;
  localparam int AUX_UNDER_BIT = 1;
  localparam int MAIN_UNDER_BIT = 0;
  localparam int BUS_SILENCE_BIT = 4;
  localparam int BUS_FAULT_BIT = 1;
  localparam int BUS_WAKEUP_BIT = 0;
  localparam int WAKE_RISE_BIT = 1;
  localparam int WAKE_FALL_BIT = 0;

  // implemented bits per register; everything else reads as zero
  localparam logic [7:0] SYS_MASK = 8'h06;
  localparam logic [7:0] SUP_MASK = 8'h07;
  localparam logic [7:0] TRX_MASK = 8'h13;
  localparam logic [7:0] WAKE_MASK = 8'h03;

  // reset values
  localparam logic [7:0] SYS_EN_RESET = 8'h00;
  localparam logic [7:0] SUP_EN_RESET = 8'h00;
  localparam logic [7:0] TRX_EN_RESET = 8'h00;
  localparam logic [7:0] WAKE_EN_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // transceiver mode code in which supply undervoltage counts as a bus fault
  localparam logic [1:0] MODE_FIELD_FAULT = 2'h1;

  // legal serial command lengths in clock counts
  localparam logic [5:0] FRAME_BITS_16 = 6'h10;
  localparam logic [5:0] FRAME_BITS_24 = 6'h18;
  localparam logic [5:0] FRAME_BITS_32 = 6'h20;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SILENCE_TIMEOUT_NS = 1000000;
  localparam int SILENCE_CYCLES = (SILENCE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ---- sticky_flags.sv ----
`timescale 1ns/10ps

// bank of sticky event bits: a qualified event sets, a write of one clears,
// and an event in the clearing cycle wins so nothing is lost
module sticky_flags #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [W-1:0] event_i, // raw event conditions
  input wire logic [W-1:0] enable_i, // per-bit capture enable
  input wire logic [W-1:0] clear_i, // per-bit clear request
  output logic [W-1:0] flag_o // captured flags
);

  logic [W-1:0] flag_next;

  always_comb begin
    flag_next = (flag_o & ~clear_i) | (event_i & enable_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= RESET_VAL;
    end else begin
      flag_o <= flag_next;
    end
  end

endmodule // sticky_flags

// ---- event_capture_status_enable.sv ----
`timescale 1ns/10ps

module event_capture_status_enable
  import event_capture_pkg::*;
#(
  parameter int unsigned SILENCE_CYCLES_P = SILENCE_CYCLES
) (
  input wire logic clk_i, // 20 MHz system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [6:0] reg_addr_i, // register address
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe, one cycle
  input wire logic reg_rd_i, // read strobe, one cycle
  output logic [7:0] reg_rdata_o, // read data, valid the cycle after reg_rd_i
  input wire logic sleep_mode_i, // device in Sleep mode
  input wire logic [1:0] transceiver_mode_field_i, // transceiver mode control code
  input wire logic bus_supply_under_i, // transceiver off due to its supply undervoltage
  input wire logic txd_clamped_i, // transmit input stuck dominant
  input wire logic transceiver_offline_i, // transceiver in offline mode
  input wire logic bus_wake_event_i, // bus wake-up pattern detected, one cycle
  input wire logic bus_rx_i, // received bus level
  input wire logic wake_pin_i, // WAKE input level
  input wire logic overtemp_i, // temperature above warning threshold
  input wire logic frame_done_i, // serial command finished, one cycle
  input wire logic [5:0] frame_bits_i, // clock count of that command
  input wire logic illegal_mode_i, // illegal mode code received, one cycle
  input wire logic locked_write_i, // write to locked register tried, one cycle
  input wire logic aux_over_i, // second regulator or external supply overvoltage
  input wire logic aux_under_i, // second regulator or external supply undervoltage
  input wire logic main_under_i, // main regulator undervoltage
  output logic [7:0] sys_status_o, // system event status bits
  output logic [7:0] sup_status_o, // supply event status bits
  output logic [7:0] trx_status_o, // transceiver event status bits
  output logic [7:0] wake_status_o, // WAKE pin event status bits
  output logic event_pending_o // some enabled event captured
);

  // enable registers
  logic [7:0] sys_en_reg;
  logic [7:0] sup_en_reg;
  logic [7:0] trx_en_reg;
  logic [7:0] wake_en_reg;

  // status banks
  logic [7:0] sys_status;
  logic [7:0] sup_status;
  logic [7:0] trx_status;
  logic [7:0] wake_status;
  logic [7:0] sys_event;
  logic [7:0] sup_event;
  logic [7:0] trx_event;
  logic [7:0] wake_event;
  logic [7:0] sys_clear;
  logic [7:0] sup_clear;
  logic [7:0] trx_clear;
  logic [7:0] wake_clear;

  // pin history
  logic wake_prev_reg;
  logic bus_prev_reg;
  logic pins_valid_reg;
  logic wake_rise;
  logic wake_fall;
  logic bus_edge;

  // silence detection
  logic [31:0] silence_cnt_reg;
  logic bus_active_reg;
  logic silence_hit;

  // serial failure decode
  logic frame_len_bad;
  logic serial_fault;

  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic pending_reg;

  // ---------------- enable registers ----------------

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_en_reg <= SYS_EN_RESET;
    end else if (reg_wr_i && reg_addr_i == SYS_EN_ADDR) begin
      sys_en_reg <= reg_wdata_i & SYS_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sup_en_reg <= SUP_EN_RESET;
    end else if (reg_wr_i && reg_addr_i == SUP_EN_ADDR) begin
      sup_en_reg <= reg_wdata_i & SUP_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trx_en_reg <= TRX_EN_RESET;
    end else if (reg_wr_i && reg_addr_i == TRX_EN_ADDR) begin
      trx_en_reg <= reg_wdata_i & TRX_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_en_reg <= WAKE_EN_RESET;
    end else if (reg_wr_i && reg_addr_i == WAKE_EN_ADDR) begin
      wake_en_reg <= reg_wdata_i & WAKE_MASK;
    end
  end

  // ---------------- pin edge detection ----------------

  // the first cycle after reset only loads history, so a pin that is
  // already high at reset is not mistaken for a rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_prev_reg <= 1'b0;
      bus_prev_reg <= 1'b0;
      pins_valid_reg <= 1'b0;
    end else begin
      wake_prev_reg <= wake_pin_i;
      bus_prev_reg <= bus_rx_i;
      pins_valid_reg <= 1'b1;
    end
  end

  assign wake_rise = pins_valid_reg && !wake_prev_reg && wake_pin_i;
  assign wake_fall = pins_valid_reg && wake_prev_reg && !wake_pin_i;
  assign bus_edge = pins_valid_reg && (bus_prev_reg != bus_rx_i);

  // ---------------- bus silence timer ----------------

  // any bus edge restarts the timer; the flag only fires once per active
  // period because bus_active_reg drops when silence is reported
  assign silence_hit = bus_active_reg && !bus_edge && (silence_cnt_reg >= SILENCE_CYCLES_P - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      silence_cnt_reg <= 32'h0;
    end else if (bus_edge || !bus_active_reg) begin
      silence_cnt_reg <= 32'h0;
    end else if (!silence_hit) begin
      silence_cnt_reg <= silence_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_active_reg <= 1'b0;
    end else if (bus_edge) begin
      bus_active_reg <= 1'b1;
    end else if (silence_hit) begin
      bus_active_reg <= 1'b0;
    end
  end

  // ---------------- serial failure ----------------

  assign frame_len_bad = frame_done_i && (frame_bits_i != FRAME_BITS_16)
    && (frame_bits_i != FRAME_BITS_24) && (frame_bits_i != FRAME_BITS_32);
  assign serial_fault = !sleep_mode_i
    && (frame_len_bad || illegal_mode_i || locked_write_i);

  // ---------------- event conditions ----------------

  always_comb begin
    sys_event = 8'h00;
    sys_event[OVERTEMP_BIT] = overtemp_i && !sleep_mode_i;
    sys_event[SERIAL_FAULT_BIT] = serial_fault;
  end

  always_comb begin
    sup_event = 8'h00;
    sup_event[AUX_OVER_BIT] = aux_over_i;
    sup_event[AUX_UNDER_BIT] = aux_under_i;
    // main regulator is off in Sleep, so its undervoltage is not an event there
    sup_event[MAIN_UNDER_BIT] = main_under_i && !sleep_mode_i;
  end

  always_comb begin
    trx_event = 8'h00;
    trx_event[BUS_SILENCE_BIT] = silence_hit;
    trx_event[BUS_FAULT_BIT] = !sleep_mode_i
      && ((transceiver_mode_field_i == MODE_FIELD_FAULT && bus_supply_under_i) || txd_clamped_i);
    trx_event[BUS_WAKEUP_BIT] = bus_wake_event_i && transceiver_offline_i;
  end

  always_comb begin
    wake_event = 8'h00;
    wake_event[WAKE_RISE_BIT] = wake_rise;
    wake_event[WAKE_FALL_BIT] = wake_fall;
  end

  // ---------------- write-one-to-clear decode ----------------

  always_comb begin
    sys_clear = 8'h00;
    sup_clear = 8'h00;
    trx_clear = 8'h00;
    wake_clear = 8'h00;
    if (reg_wr_i) begin
      if (reg_addr_i == SYS_ST_ADDR) begin
        sys_clear = reg_wdata_i & SYS_MASK;
      end
      if (reg_addr_i == SUP_ST_ADDR) begin
        sup_clear = reg_wdata_i & SUP_MASK;
      end
      if (reg_addr_i == TRX_ST_ADDR) begin
        trx_clear = reg_wdata_i & TRX_MASK;
      end
      if (reg_addr_i == WAKE_ST_ADDR) begin
        wake_clear = reg_wdata_i & WAKE_MASK;
      end
    end
  end

  // ---------------- status banks ----------------

  sticky_flags #(
    .W(8),
    .RESET_VAL(STATUS_RESET)
  ) u_sys_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(sys_event),
    .enable_i(sys_en_reg & SYS_MASK),
    .clear_i(sys_clear),
    .flag_o(sys_status)
  );

  sticky_flags #(
    .W(8),
    .RESET_VAL(STATUS_RESET)
  ) u_sup_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(sup_event),
    .enable_i(sup_en_reg & SUP_MASK),
    .clear_i(sup_clear),
    .flag_o(sup_status)
  );

  sticky_flags #(
    .W(8),
    .RESET_VAL(STATUS_RESET)
  ) u_trx_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(trx_event),
    .enable_i(trx_en_reg & TRX_MASK),
    .clear_i(trx_clear),
    .flag_o(trx_status)
  );

  sticky_flags #(
    .W(8),
    .RESET_VAL(STATUS_RESET)
  ) u_wake_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(wake_event),
    .enable_i(wake_en_reg & WAKE_MASK),
    .clear_i(wake_clear),
    .flag_o(wake_status)
  );

  assign sys_status_o = sys_status;
  assign sup_status_o = sup_status;
  assign trx_status_o = trx_status;
  assign wake_status_o = wake_status;

  // ---------------- read path ----------------

  always_comb begin
    case (reg_addr_i)
      SYS_EN_ADDR: rdata_next = sys_en_reg;
      SUP_EN_ADDR: rdata_next = sup_en_reg;
      TRX_EN_ADDR: rdata_next = trx_en_reg;
      WAKE_EN_ADDR: rdata_next = wake_en_reg;
      SYS_ST_ADDR: rdata_next = sys_status & SYS_MASK;
      SUP_ST_ADDR: rdata_next = sup_status & SUP_MASK;
      TRX_ST_ADDR: rdata_next = trx_status & TRX_MASK;
      WAKE_ST_ADDR: rdata_next = wake_status & WAKE_MASK;
      default: rdata_next = 8'h00;
    endcase
  end

  // read data is held until the next read so a slow shifter can take it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= RDATA_RESET;
    end else if (reg_rd_i) begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending_reg <= 1'b0;
    end else begin
      pending_reg <= |{sys_status, sup_status, trx_status, wake_status};
    end
  end

  assign event_pending_o = pending_reg;

endmodule // event_capture_status_enable

// ---- event_capture_status_enable_chk.sv ----
`timescale 1ns/10ps
module event_capture_status_enable_chk
  import event_capture_pkg::*;
#(
  parameter int unsigned SILENCE_CYCLES_P = SILENCE_CYCLES
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic [6:0] reg_addr_i, // address
  input wire logic [7:0] reg_wdata_i, // wdata
  input wire logic reg_wr_i, // write
  input wire logic reg_rd_i, // read
  input wire logic [7:0] reg_rdata_o, // rdata
  input wire logic sleep_mode_i, // sleep
  input wire logic [1:0] transceiver_mode_field_i, // mode
  input wire logic bus_supply_under_i, // supply low
  input wire logic txd_clamped_i, // txd stuck
  input wire logic transceiver_offline_i, // offline
  input wire logic bus_wake_event_i, // bus wake
  input wire logic bus_rx_i, // bus level
  input wire logic wake_pin_i, // pin
  input wire logic overtemp_i, // hot
  input wire logic [7:0] sys_status_o, // sys
  input wire logic [7:0] sup_status_o, // sup
  input wire logic [7:0] trx_status_o, // trx
  input wire logic [7:0] wake_status_o, // wake
  input wire logic event_pending_o // pending
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  int unsigned quiet_cnt;
  logic rx_prev;
  // saturates so a long quiet spell never wraps back to a short one
  always_ff @(posedge clk_i) begin
    rx_prev <= bus_rx_i;
    if (rst_i || bus_rx_i != rx_prev) begin
      quiet_cnt <= 0;
    end else if (quiet_cnt < SILENCE_CYCLES_P) begin
      quiet_cnt <= quiet_cnt + 1;
    end
  end
  rise_cause_a: assert property (
    $rose(wake_status_o[1]) |-> $past(wake_pin_i) && !$past(wake_pin_i, 2))
    else $error("rise flag without rising pin");
  fall_cause_a: assert property (
    $rose(wake_status_o[0]) |-> !$past(wake_pin_i) && $past(wake_pin_i, 2))
    else $error("fall flag without falling pin");
  bus_fault_a: assert property (
    $rose(trx_status_o[1]) |-> $past(!sleep_mode_i && (txd_clamped_i ||
      (transceiver_mode_field_i == MODE_FIELD_FAULT && bus_supply_under_i))))
    else $error("bus fault flag without cause");
  bus_wake_a: assert property (
    $rose(trx_status_o[0]) |-> $past(bus_wake_event_i && transceiver_offline_i))
    else $error("bus wake flag without cause");
  overtemp_set_a: assert property (
    $rose(sys_status_o[2]) |-> $past(overtemp_i && !sleep_mode_i))
    else $error("overtemp flag without cause");
  silence_wait_a: assert property (
    $rose(trx_status_o[4]) |-> quiet_cnt >= SILENCE_CYCLES_P)
    else $error("silence flag too early");
  clear_only_a: assert property (
    !$past(rst_i) && $fell(trx_status_o[1]) |->
      $past(reg_wr_i && reg_addr_i == TRX_ST_ADDR && reg_wdata_i[1]))
    else $error("bus fault flag dropped without clear");
  reserved_zero_a: assert property (
    ((sys_status_o & ~SYS_MASK) | (sup_status_o & ~SUP_MASK) |
      (trx_status_o & ~TRX_MASK) | (wake_status_o & ~WAKE_MASK)) == 8'h00)
    else $error("reserved status bit set");
  read_data_a: assert property (
    reg_rd_i && reg_addr_i == WAKE_ST_ADDR |=> reg_rdata_o == $past(wake_status_o))
    else $error("wake status read wrong");
  pending_or_a: assert property (
    !$past(rst_i) |-> event_pending_o ==
      $past(|{sys_status_o, sup_status_o, trx_status_o, wake_status_o}))
    else $error("pending not the or of flags");
  cover property ($rose(wake_status_o[1]));
  cover property ($rose(trx_status_o[4]));
  cover property ($fell(trx_status_o[1]));
endmodule // event_capture_status_enable_chk

bind event_capture_status_enable event_capture_status_enable_chk #(
  .SILENCE_CYCLES_P(SILENCE_CYCLES_P)
) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .sleep_mode_i(sleep_mode_i), .transceiver_mode_field_i(transceiver_mode_field_i),
  .bus_supply_under_i(bus_supply_under_i), .txd_clamped_i(txd_clamped_i),
  .transceiver_offline_i(transceiver_offline_i), .bus_wake_event_i(bus_wake_event_i),
  .bus_rx_i(bus_rx_i), .wake_pin_i(wake_pin_i), .overtemp_i(overtemp_i),
  .sys_status_o(sys_status_o), .sup_status_o(sup_status_o), .trx_status_o(trx_status_o),
  .wake_status_o(wake_status_o), .event_pending_o(event_pending_o));

// ---- host_model.sv ----
`timescale 1ns/10ps
module host_model (
  output logic [6:0] reg_addr_o, // address
  output logic [7:0] reg_wdata_o, // write data
  output logic reg_wr_o, // write strobe
  output logic reg_rd_o // read strobe
);
  initial begin
    reg_addr_o = 7'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // caller sits just after an edge, so the access is held over exactly one edge
  task automatic put(input logic w, input logic r, input logic [6:0] a, input logic [7:0] d);
    reg_wr_o = w;
    reg_rd_o = r;
    reg_addr_o = a;
    reg_wdata_o = d;
  endtask
  // released lines flip so a stale value cannot pass for a live one
  task automatic idle();
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
  endtask
endmodule // host_model

// ---- event_capture_status_enable_tb.sv ----
`timescale 1ns/10ps
module event_capture_status_enable_tb;
  import event_capture_pkg::*;
  localparam int unsigned P = 20;
  localparam logic [6:0] AT [9] = '{SYS_EN_ADDR, SUP_EN_ADDR, TRX_EN_ADDR, WAKE_EN_ADDR,
    SYS_ST_ADDR, SUP_ST_ADDR, TRX_ST_ADDR, WAKE_ST_ADDR, 7'h10};
  localparam logic [7:0] MK [4] = '{SYS_MASK, SUP_MASK, TRX_MASK, WAKE_MASK};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [21:0] stim = 22'h000000;
  logic [6:0] addr;
  logic [7:0] wdata, rdata;
  logic wr, rd, pend, pend_m, pw, prx, armed;
  logic [7:0] st_o [4];
  logic [7:0] en_m [4];
  logic [7:0] st_m [4];
  logic [16:0] lf = 17'h16186;
  int sil;
  int num_errors = 0;
  int checks_done = 0;
  always #25 clk_i = ~clk_i;
  host_model host_u (.reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
  event_capture_status_enable #(.SILENCE_CYCLES_P(P)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .sleep_mode_i(stim[0]),
    .transceiver_mode_field_i(stim[15:14]), .bus_supply_under_i(stim[1]),
    .txd_clamped_i(stim[2]), .transceiver_offline_i(stim[3]), .bus_wake_event_i(stim[4]),
    .bus_rx_i(stim[5]), .wake_pin_i(stim[6]), .overtemp_i(stim[7]), .frame_done_i(stim[8]),
    .frame_bits_i(stim[21:16]), .illegal_mode_i(stim[9]), .locked_write_i(stim[10]),
    .aux_over_i(stim[11]), .aux_under_i(stim[12]), .main_under_i(stim[13]),
    .sys_status_o(st_o[0]), .sup_status_o(st_o[1]), .trx_status_o(st_o[2]),
    .wake_status_o(st_o[3]), .event_pending_o(pend));
  // reference updates at the edge; compares happen 2 ns later
  always @(posedge clk_i) begin : model
    logic [7:0] ev [4];
    logic s, hit;
    s = stim[0];
    hit = 1'b0;
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        en_m[i] = 8'h00;
        st_m[i] = 8'h00;
      end
      pend_m = 1'b0;
      armed = 1'b0;
    end else begin
      if (stim[5] != prx) begin
        sil = 0;
        armed = 1'b1;
      end else if (armed) begin
        sil++;
        hit = (sil == P);
        armed = !hit;
      end
      ev[0] = {5'h00, stim[7] & !s, !s & (stim[9] | stim[10] | (stim[8] &
        !(stim[21:16] inside {FRAME_BITS_16, FRAME_BITS_24, FRAME_BITS_32}))), 1'b0};
      ev[1] = {5'h00, stim[11], stim[12], stim[13] & !s};
      ev[2] = {3'h0, hit, 2'h0, !s & (stim[2] | (stim[15:14] == MODE_FIELD_FAULT & stim[1])),
        stim[4] & stim[3]};
      ev[3] = {6'h00, stim[6] & !pw, !stim[6] & pw};
      pend_m = |{st_m[0], st_m[1], st_m[2], st_m[3]};
      for (int i = 0; i < 4; i++) begin
        st_m[i] = (st_m[i] & ~((wr && addr == AT[i+4]) ? wdata : 8'h00)) |
          (ev[i] & en_m[i] & MK[i]);
        if (wr && addr == AT[i]) en_m[i] = wdata & MK[i];
      end
    end
    pw = stim[6];
    prx = stim[5];
  end
  function automatic logic [7:0] regval(input logic [6:0] a);
    for (int i = 0; i < 4; i++) begin
      if (a == AT[i]) return en_m[i];
      if (a == AT[i+4]) return st_m[i];
    end
    return 8'h00;
  endfunction
  function automatic logic [16:0] rnd();
    repeat (17) lf = {lf[15:0], lf[16] ^ lf[13]};
    return lf;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge clk_i);
    #2;
    for (int i = 0; i < 4; i++) check(st_o[i], st_m[i]);
    check({7'h00, pend}, {7'h00, pend_m});
  endtask
  task automatic acc(input logic w, input logic r, input logic [6:0] a, input logic [7:0] d);
    logic [7:0] e;
    host_u.put(w, r, a, d);
    e = regval(a);
    step();
    if (r) check(rdata, e);
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    num_errors++;
    print_verdict();
  end
  initial begin
    logic [33:0] x;
    repeat (8) @(posedge clk_i);
    #2;
    rst_i = 1'b0;
    for (int i = 0; i < 9; i++) acc(1'b0, 1'b1, AT[i], 8'h00);
    for (int i = 0; i < 4; i++) acc(1'b1, 1'b0, AT[i], 8'hFF);
    for (int i = 0; i < 9; i++) acc(1'b0, 1'b1, AT[i], 8'h00);
    host_u.idle();
    stim[5] = 1'b1;
    repeat (P + 4) step();
    acc(1'b1, 1'b0, TRX_ST_ADDR, 8'h10);
    host_u.idle();
    // no bus activity since the last silence, so the flag must stay clear
    repeat (P + 4) step();
    // mid-run reset; the first edge after it only reloads pin history
    rst_i = 1'b1;
    repeat (2) step();
    rst_i = 1'b0;
    step();
    for (int n = 0; n < 3000; n++) begin
      x = {rnd(), rnd()};
      stim = x[21:0];
      x = {rnd(), rnd()};
      acc(x[0], x[1], AT[x[5:2] % 9], x[13:6]);
    end
    print_verdict();
  end
endmodule // event_capture_status_enable_tb
